// ==== verilog/icm_pkg.sv ====
/*
 Constants for the interrupt-controlled clock output mask block:
 register offsets, field positions, reset values and delay times.
 Assumes a 20 MHz pclk; all delay counts are derived from the period below.
*/
package icm_pkg;

   // Clock
   localparam int unsigned CLK_PERIOD_NS        = 50;

   // Register byte offsets on APB
   localparam logic [7:0]  ADDR_CLOCK_IRQ_MASK  = 8'h14;
   localparam logic [7:0]  ADDR_EVT_STATUS      = 8'h40;
   localparam logic [7:0]  ADDR_EVT_MASK        = 8'h44;
   localparam logic [7:0]  ADDR_STATE           = 8'h48;

   // Reset values
   localparam logic [7:0]  CLOCK_IRQ_MASK_RESET = 8'h00;
   localparam logic [2:0]  EVT_MASK_RESET       = 3'h0;

   // Field positions of clock_irq_mask
   localparam int unsigned BIT_OFF_DELAY_SEL    = 7;
   localparam int unsigned BIT_INT_DELAY_EN     = 6;
   localparam int unsigned BIT_EVENT_SEL        = 5;
   localparam int unsigned BIT_ALARM_SEL        = 4;
   localparam int unsigned BIT_COUNTDOWN_SEL    = 3;
   localparam int unsigned BIT_UPDATE_SEL       = 2;
   localparam int unsigned BIT_TEMP_HIGH_SEL    = 1;
   localparam int unsigned BIT_TEMP_LOW_SEL     = 0;
   localparam int unsigned NUM_SRC              = 6;

   // Event status bits
   localparam int unsigned EVT_OUTPUT_ON        = 0;
   localparam int unsigned EVT_IRQ_RELEASED     = 1;
   localparam int unsigned EVT_OFF_EXPIRED      = 2;
   localparam int unsigned NUM_EVT              = 3;

   // State register bit positions
   localparam int unsigned ST_CLOCK_ON          = 0;
   localparam int unsigned ST_IRQ_HELD          = 1;
   localparam int unsigned ST_OFF_HOLD          = 2;
   localparam int unsigned ST_IRQ_REQ           = 3;

   // Delay times in ns: interrupt delay is 1/256 s to 3/512 s
   localparam int unsigned INT_DELAY_MIN_NS     = 3906250;
   localparam int unsigned INT_DELAY_MAX_NS     = 5859375;
   localparam int unsigned OFF_DELAY_SHORT_NS   = 1000000;
   localparam int unsigned OFF_DELAY_LONG_NS    = 2000000;

   // Least times round up to whole cycles, never below one
   function automatic int unsigned ns_to_cycles_up(input int unsigned ns);
      int unsigned c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int unsigned INT_DELAY_CYCLES     = ns_to_cycles_up(INT_DELAY_MIN_NS);
   localparam int unsigned OFF_SHORT_CYCLES     = ns_to_cycles_up(OFF_DELAY_SHORT_NS);
   localparam int unsigned OFF_LONG_CYCLES      = ns_to_cycles_up(OFF_DELAY_LONG_NS);
   localparam int unsigned CNT_WIDTH            = 24;

endpackage

// ==== verilog/icm_delay_counter.sv ====
/*
 One-shot down counter: start loads a cycle count, busy stays high for
 exactly that many cycles, done pulses for one cycle at the end.
 Assumes start is a single-cycle pulse synchronous to pclk.
*/
`timescale 1ns/1ps
module icm_delay_counter #(
   parameter int unsigned WIDTH = 24
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             start,
   input  wire logic [WIDTH-1:0] load_val,
   output logic                  busy,
   output logic                  done
);
   initial begin
      if (WIDTH < 2) begin
         $error("icm_delay_counter: WIDTH too small");
      end
   end

   logic [WIDTH-1:0] cnt_reg;
   logic [WIDTH-1:0] cnt_next;
   logic             done_reg;
   logic             done_next;

   wire              cnt_last = (cnt_reg == {{(WIDTH-1){1'b0}}, 1'b1});
   wire              cnt_zero = (cnt_reg == '0);

   assign cnt_next  = start ? load_val : (cnt_zero ? cnt_reg : cnt_reg - 1'b1);
   assign done_next = cnt_last & ~start;
   assign busy      = ~cnt_zero;
   assign done      = done_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg  <= '0;
         done_reg <= 1'b0;
      end else begin
         cnt_reg  <= cnt_next;
         done_reg <= done_next;
      end
   end
endmodule

// ==== verilog/icm_irq_status.sv ====
/*
 Sticky event status with write-one-to-clear, a mask of the same layout
 and one level interrupt. A set in the clearing cycle wins over the clear.
 Assumes set pulses, write strobes and data are synchronous to pclk.
*/
`timescale 1ns/1ps
module icm_irq_status
   import icm_pkg::*;
#(
   parameter int unsigned N = 3
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [N-1:0] set_evt,
   input  wire logic         clr_wr,
   input  wire logic         mask_wr,
   input  wire logic [N-1:0] wdata,
   output logic [N-1:0]      status,
   output logic [N-1:0]      mask,
   output logic              irq
);
   initial begin
      if (N != NUM_EVT) begin
         $error("icm_irq_status: N must match NUM_EVT");
      end
   end

   logic [N-1:0] status_reg;
   logic [N-1:0] status_next;
   logic [N-1:0] mask_reg;
   logic [N-1:0] mask_next;

   wire  [N-1:0] clr_bits = clr_wr ? wdata : '0;

   assign status_next = set_evt | (status_reg & ~clr_bits);
   assign mask_next   = mask_wr ? wdata : mask_reg;
   assign status      = status_reg;
   assign mask        = mask_reg;
   assign irq         = |(status_reg & mask_reg);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_reg <= '0;
         mask_reg   <= EVT_MASK_RESET;
      end else begin
         status_reg <= status_next;
         mask_reg   <= mask_next;
      end
   end
endmodule

// ==== verilog/icm_clock_irq_mask.sv ====
/*
 Interrupt-controlled clock output gate with its source mask register,
 off delay after a bus STOP and interrupt delay after the output turns on.
 Assumes an APB master on pclk, interrupt sources and STOP pulse synchronous
 to pclk, and the off-delay enable and direct gate held in other registers.
*/
// Function
// - Mask register at 14h clears to all zeros at power-on.
// - Writing one to a select bit chooses that source; any combination allowed.
// - Bit 7 picks the off delay after STOP, only when off-delay enable set.
// - Interrupt-delay bit holds selected interrupt back after output turns on, only when direct gate is set.
// - Bits 5, 4, 3 select event, alarm and countdown interrupts.
// - Select bits default to zero; a one routes the source to output control.
// - Bits 2, 1, 0 select update, high and low temperature interrupts.
`timescale 1ns/1ps
module icm_clock_irq_mask
   import icm_pkg::*;
#(
   parameter int unsigned INT_DELAY_CNT = INT_DELAY_CYCLES,
   parameter int unsigned OFF_SHORT_CNT = OFF_SHORT_CYCLES,
   parameter int unsigned OFF_LONG_CNT  = OFF_LONG_CYCLES
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        write_protect,
   input  wire logic        external_event_input,
   input  wire logic        alarm_irq_signal,
   input  wire logic        countdown_irq_signal,
   input  wire logic        update_irq_signal,
   input  wire logic        temp_high_irq_signal,
   input  wire logic        temp_low_irq_signal,
   input  wire logic        bus_stop_detect,
   input  wire logic        off_delay_enable,
   input  wire logic        direct_output_gate,
   output logic             output_clock_pin_en,
   output logic             irq_gated_out,
   output logic             irq
);
   localparam logic [CNT_WIDTH-1:0] INT_LOAD   = CNT_WIDTH'(INT_DELAY_CNT);
   localparam logic [CNT_WIDTH-1:0] SHORT_LOAD = CNT_WIDTH'(OFF_SHORT_CNT);
   localparam logic [CNT_WIDTH-1:0] LONG_LOAD  = CNT_WIDTH'(OFF_LONG_CNT);

   initial begin
      if (INT_DELAY_CNT < 1 || INT_DELAY_CNT >= (1 << CNT_WIDTH) ||
          OFF_SHORT_CNT < 1 || OFF_SHORT_CNT >= (1 << CNT_WIDTH) ||
          OFF_LONG_CNT < 1  || OFF_LONG_CNT >= (1 << CNT_WIDTH)) begin
         $error("icm_clock_irq_mask: delay count out of range");
      end
   end

   // Registers
   logic [7:0]           mask_reg;
   logic [7:0]           mask_next;
   logic                 clk_on_reg;
   logic                 clk_on_next;
   logic                 irq_out_reg;
   logic                 irq_out_next;
   logic [31:0]          prdata_reg;
   logic [31:0]          prdata_next;
   logic                 err_reg;
   logic                 err_next;

   // APB decode
   wire                  setup_ph    = psel & ~penable;
   wire                  access_ph   = psel & penable;
   wire                  hit_mask    = (paddr == ADDR_CLOCK_IRQ_MASK);
   wire                  hit_status  = (paddr == ADDR_EVT_STATUS);
   wire                  hit_emask   = (paddr == ADDR_EVT_MASK);
   wire                  hit_state   = (paddr == ADDR_STATE);
   wire                  hit_any     = hit_mask | hit_status | hit_emask | hit_state;
   wire                  wr_access   = access_ph & pwrite;
   wire                  mask_wr     = wr_access & hit_mask & ~write_protect;
   wire                  status_wr   = wr_access & hit_status;
   wire                  emask_wr    = wr_access & hit_emask;
   wire                  bad_req     = ~hit_any | (pwrite & hit_mask & write_protect);

   // Source routing
   wire  [NUM_SRC-1:0]   irq_src;
   wire  [NUM_SRC-1:0]   sel_hits;
   wire                  irq_req;
   wire                  int_busy;
   wire                  int_done;
   wire                  hold_busy;
   wire                  hold_done;
   wire                  int_start;
   wire                  hold_start;
   wire                  clk_rise;
   wire  [CNT_WIDTH-1:0] hold_load;
   wire  [NUM_EVT-1:0]   evt_set;
   wire  [NUM_EVT-1:0]   evt_status;
   wire  [NUM_EVT-1:0]   evt_mask;
   wire  [3:0]           state_bits;
   wire  [31:0]          rd_mux;

   assign irq_src[BIT_EVENT_SEL]     = external_event_input;
   assign irq_src[BIT_ALARM_SEL]     = alarm_irq_signal;
   assign irq_src[BIT_COUNTDOWN_SEL] = countdown_irq_signal;
   assign irq_src[BIT_UPDATE_SEL]    = update_irq_signal;
   assign irq_src[BIT_TEMP_HIGH_SEL] = temp_high_irq_signal;
   assign irq_src[BIT_TEMP_LOW_SEL]  = temp_low_irq_signal;

   // Each source gated by its own select bit, then ORed
   assign sel_hits    = mask_reg[NUM_SRC-1:0] & irq_src;
   assign irq_req     = |sel_hits;

   // Output on while any selected source or the off hold is active
   assign clk_on_next = irq_req | hold_start | hold_busy;
   assign clk_rise    = clk_on_next & ~clk_on_reg;

   // Interrupt delay starts when the output turns on with bit 6 and direct gate set
   assign int_start   = clk_rise & mask_reg[BIT_INT_DELAY_EN] & direct_output_gate;
   assign irq_out_next = irq_req & ~(int_start | int_busy);

   // Off delay after STOP, length chosen by bit 7
   assign hold_start  = bus_stop_detect & off_delay_enable;
   assign hold_load   = mask_reg[BIT_OFF_DELAY_SEL] ? LONG_LOAD : SHORT_LOAD;

   assign mask_next   = mask_wr ? pwdata[7:0] : mask_reg;

   assign evt_set[EVT_OUTPUT_ON]    = clk_rise;
   assign evt_set[EVT_IRQ_RELEASED] = int_done;
   assign evt_set[EVT_OFF_EXPIRED]  = hold_done;

   assign state_bits[ST_CLOCK_ON] = clk_on_reg;
   assign state_bits[ST_IRQ_HELD] = int_busy;
   assign state_bits[ST_OFF_HOLD] = hold_busy;
   assign state_bits[ST_IRQ_REQ]  = irq_req;

   assign rd_mux = hit_mask   ? {24'h00_0000, mask_reg} :
                   hit_status ? {29'h0000_0000, evt_status} :
                   hit_emask  ? {29'h0000_0000, evt_mask} :
                   hit_state  ? {28'h000_0000, state_bits} :
                   32'h0000_0000;

   assign prdata_next = (setup_ph & ~pwrite) ? rd_mux : prdata_reg;
   assign err_next    = setup_ph ? bad_req : err_reg;

   assign prdata              = prdata_reg;
   assign pready              = 1'b1;
   assign pslverr             = access_ph & err_reg;
   assign output_clock_pin_en = clk_on_reg;
   assign irq_gated_out       = irq_out_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_reg    <= CLOCK_IRQ_MASK_RESET;
         clk_on_reg  <= 1'b0;
         irq_out_reg <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
         err_reg     <= 1'b0;
      end else begin
         mask_reg    <= mask_next;
         clk_on_reg  <= clk_on_next;
         irq_out_reg <= irq_out_next;
         prdata_reg  <= prdata_next;
         err_reg     <= err_next;
      end
   end

   icm_delay_counter #(
      .WIDTH    (CNT_WIDTH)
   ) u_int_delay (
      .pclk     (pclk),
      .presetn  (presetn),
      .start    (int_start),
      .load_val (INT_LOAD),
      .busy     (int_busy),
      .done     (int_done)
   );

   icm_delay_counter #(
      .WIDTH    (CNT_WIDTH)
   ) u_off_hold (
      .pclk     (pclk),
      .presetn  (presetn),
      .start    (hold_start),
      .load_val (hold_load),
      .busy     (hold_busy),
      .done     (hold_done)
   );

   icm_irq_status #(
      .N        (NUM_EVT)
   ) u_status (
      .pclk     (pclk),
      .presetn  (presetn),
      .set_evt  (evt_set),
      .clr_wr   (status_wr),
      .mask_wr  (emask_wr),
      .wdata    (pwdata[NUM_EVT-1:0]),
      .status   (evt_status),
      .mask     (evt_mask),
      .irq      (irq)
   );

   // Checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   chk_mask_reset: assert property (
      $rose(presetn) |-> (mask_reg == CLOCK_IRQ_MASK_RESET) && !output_clock_pin_en)
      else $error("mask not zero after reset");

   chk_mask_write: assert property (
      (access_ph && pwrite && hit_mask && !write_protect) |=> mask_reg == $past(pwdata[7:0]))
      else $error("mask write lost");

   chk_mask_protect: assert property (
      (access_ph && pwrite && hit_mask && write_protect) |=> $stable(mask_reg))
      else $error("protected mask write took effect");

   chk_off_delay_gate: assert property (
      $rose(hold_busy) |-> $past(off_delay_enable && bus_stop_detect))
      else $error("off hold started without enable");

   chk_off_delay_len: assert property (
      (hold_start && !irq_req && !mask_reg[BIT_OFF_DELAY_SEL] && OFF_SHORT_CNT > 2)
      |=> output_clock_pin_en ##1 output_clock_pin_en)
      else $error("off hold did not keep output on");

   chk_int_held: assert property (
      $past(int_busy) |-> !irq_gated_out)
      else $error("interrupt passed during delay");

   chk_int_nodelay: assert property (
      (irq_req && !int_busy && !int_start) |=> irq_gated_out)
      else $error("undelayed interrupt not passed");

   chk_high_srcs: assert property (
      (|(mask_reg[5:3] & irq_src[5:3])) |=> output_clock_pin_en)
      else $error("event, alarm or countdown source ignored");

   chk_low_srcs: assert property (
      (|(mask_reg[2:0] & irq_src[2:0])) |=> output_clock_pin_en)
      else $error("update or temperature source ignored");

   chk_unselected: assert property (
      (sel_hits == '0 && !hold_start && !hold_busy) |=> !output_clock_pin_en)
      else $error("output on with no selected source");

   chk_or_combine: assert property (
      output_clock_pin_en == $past(|(mask_reg[NUM_SRC-1:0] & irq_src) | hold_start | hold_busy))
      else $error("output not OR of selected sources");

   chk_irq_level: assert property (
      irq == |(evt_status & evt_mask))
      else $error("interrupt line mismatch");

   cov_output_on:   cover property ($rose(output_clock_pin_en));
   cov_int_release: cover property (int_done ##1 irq_gated_out);
   cov_off_hold:    cover property (hold_start ##1 hold_busy && !irq_req);
   cov_multi_sel:   cover property ($countones(sel_hits) > 1);
endmodule

// ==== sim/icm_clock_irq_mask_bench.sv ====
/*
 Self-checking bench for the interrupt-controlled clock output mask block.
 Assumes the design package icm_pkg and an APB slave with pready answers.
*/
`timescale 1ns/1ps
module icm_clock_irq_mask_bench;
   import icm_pkg::*;

   typedef struct {
      logic [7:0] mask;
      logic [5:0] src;
      logic       exp_on;
   } icm_row_t;

   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        write_protect = 1'b0;
   logic [5:0]  src = 6'h00;
   logic        bus_stop_detect = 1'b0;
   logic        off_delay_enable = 1'b0;
   logic        direct_output_gate = 1'b0;
   logic        output_clock_pin_en;
   logic        irq_gated_out;
   logic        irq;
   int          n_mismatch = 0;
   int          comparisons = 0;
   logic [31:0] rd;
   logic        err;
   int          n;
   int          k;
   int          lo;
   int          hi;
   icm_row_t    rows [12];

   always #25 pclk = ~pclk;

   icm_clock_irq_mask #(
      .INT_DELAY_CNT (8),
      .OFF_SHORT_CNT (4),
      .OFF_LONG_CNT  (10)
   ) u_dut (
      .pclk                 (pclk),
      .presetn              (presetn),
      .psel                 (psel),
      .penable              (penable),
      .pwrite               (pwrite),
      .paddr                (paddr),
      .pwdata               (pwdata),
      .prdata               (prdata),
      .pready               (pready),
      .pslverr              (pslverr),
      .write_protect        (write_protect),
      .external_event_input (src[5]),
      .alarm_irq_signal     (src[4]),
      .countdown_irq_signal (src[3]),
      .update_irq_signal    (src[2]),
      .temp_high_irq_signal (src[1]),
      .temp_low_irq_signal  (src[0]),
      .bus_stop_detect      (bus_stop_detect),
      .off_delay_enable     (off_delay_enable),
      .direct_output_gate   (direct_output_gate),
      .output_clock_pin_en  (output_clock_pin_en),
      .irq_gated_out        (irq_gated_out),
      .irq                  (irq)
   );

   task automatic end_of_test();
      $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      chk32({31'h0, got}, {31'h0, exp});
   endtask

   // One APB transfer; release happens at the edge where pready is seen
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int t;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      t = 0;
      do begin
         @(posedge pclk);
         t++;
      end while (pready !== 1'b1 && t < 50);
      if (pready !== 1'b1) begin
         n_mismatch++;
         end_of_test();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic cyc(input int c);
      repeat (c) @(negedge pclk);
   endtask

   task automatic drive_src(input logic [5:0] s);
      @(posedge pclk);
      src <= s;
   endtask

   initial begin
      repeat (20000) @(posedge pclk);
      n_mismatch++;
      end_of_test();
   end

   initial begin
      rows = '{'{8'h20, 6'h20, 1'b1}, '{8'h10, 6'h10, 1'b1}, '{8'h08, 6'h08, 1'b1},
               '{8'h04, 6'h04, 1'b1}, '{8'h02, 6'h02, 1'b1}, '{8'h01, 6'h01, 1'b1},
               '{8'h01, 6'h3e, 1'b0}, '{8'h20, 6'h1f, 1'b0}, '{8'h00, 6'h3f, 1'b0},
               '{8'h3f, 6'h04, 1'b1}, '{8'h80, 6'h3f, 1'b0}, '{8'h40, 6'h3f, 1'b0}};
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 8'h14, 32'h0);
      chk32(rd, 32'h0000_0000);
      apb(1'b0, 8'h44, 32'h0);
      chk32(rd, 32'h0000_0000);
      $display("test reset values done");
      foreach (rows[i]) begin
         apb(1'b1, 8'h14, {24'h0, rows[i].mask});
         apb(1'b0, 8'h14, 32'h0);
         chk32(rd, {24'h0, rows[i].mask});
         drive_src(rows[i].src);
         cyc(3);
         chk1(output_clock_pin_en, rows[i].exp_on);
         chk1(irq_gated_out, rows[i].exp_on);
         drive_src(6'h00);
         cyc(3);
         chk1(output_clock_pin_en, 1'b0);
      end
      $display("test source rows done");
      apb(1'b1, 8'h14, 32'hffff_ffff);
      apb(1'b0, 8'h14, 32'h0);
      chk32(rd, 32'h0000_00ff);
      @(posedge pclk);
      write_protect <= 1'b1;
      apb(1'b1, 8'h14, 32'h0000_0000);
      chk1(err, 1'b1);
      apb(1'b0, 8'h14, 32'h0);
      chk32(rd, 32'h0000_00ff);
      @(posedge pclk);
      write_protect <= 1'b0;
      apb(1'b0, 8'h20, 32'h0);
      chk32(rd, 32'h0000_0000);
      chk1(err, 1'b1);
      $display("test protect and unmapped done");
      // Interrupt delay after output on, with and without direct gate
      for (int g = 1; g >= 0; g--) begin
         apb(1'b1, 8'h14, 32'h0000_0048);
         @(posedge pclk);
         direct_output_gate <= g[0];
         drive_src(6'h08);
         n = 0;
         while (output_clock_pin_en !== 1'b1 && n < 20) begin
            cyc(1);
            n++;
         end
         k = 0;
         while (irq_gated_out !== 1'b1 && k < 40) begin
            cyc(1);
            k++;
         end
         lo = g ? 8 : 0;
         hi = g ? 10 : 1;
         chk1(k >= lo && k <= hi, 1'b1);
         drive_src(6'h00);
         cyc(4);
      end
      $display("test interrupt delay done");
      // Off hold after STOP: short, long, and hold disabled
      for (int c = 0; c < 3; c++) begin
         apb(1'b1, 8'h14, (c > 0) ? 32'h0000_0088 : 32'h0000_0008);
         @(posedge pclk);
         off_delay_enable <= (c < 2);
         apb(1'b1, 8'h40, 32'h0000_0007);
         drive_src(6'h08);
         cyc(3);
         @(posedge pclk);
         src <= 6'h00;
         bus_stop_detect <= 1'b1;
         @(posedge pclk);
         bus_stop_detect <= 1'b0;
         cyc(1);
         k = 0;
         while (output_clock_pin_en === 1'b1 && k < 40) begin
            cyc(1);
            k++;
         end
         lo = (c == 0) ? 3 : (c == 1) ? 9 : 0;
         hi = (c == 0) ? 6 : (c == 1) ? 12 : 1;
         chk1(k >= lo && k <= hi, 1'b1);
         cyc(2);
         apb(1'b0, 8'h40, 32'h0);
         chk1(rd[2], c < 2);
      end
      $display("test off hold done");
      // Event interrupt: raise, mask, clear
      apb(1'b1, 8'h40, 32'h0000_0007);
      apb(1'b1, 8'h44, 32'h0000_0001);
      apb(1'b1, 8'h14, 32'h0000_0008);
      drive_src(6'h08);
      cyc(3);
      chk1(irq, 1'b1);
      apb(1'b0, 8'h48, 32'h0);
      chk1(rd[0], 1'b1);
      apb(1'b1, 8'h44, 32'h0000_0000);
      cyc(1);
      chk1(irq, 1'b0);
      apb(1'b1, 8'h44, 32'h0000_0001);
      cyc(1);
      chk1(irq, 1'b1);
      apb(1'b1, 8'h40, 32'h0000_0001);
      cyc(1);
      chk1(irq, 1'b0);
      $display("test event interrupt done");
      // Reset in mid-run clears the mask
      apb(1'b1, 8'h14, 32'h0000_00ff);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      cyc(1);
      chk1(output_clock_pin_en, 1'b0);
      apb(1'b0, 8'h14, 32'h0);
      chk32(rd, 32'h0000_0000);
      $display("test mid-run reset done");
      end_of_test();
   end
endmodule
